// *** sser_status.sv ***
// Questionable/operation status groups, summary bits and error queue
`timescale 1ns/1ps
module sser_status (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Monitored instrument conditions
   input wire logic volt_ovl_i,
   input wire logic curr_ovl_i,
   input wire logic freq_null_i,
   input wire logic ohm_ovl_i,
   input wire logic cap_ovl_i,
   input wire logic lim_lo_i,
   input wire logic lim_hi_i,
   // Command port
   input wire logic cmd_valid_i,
   input wire sser_pkg::sser_cmd_t cmd_i,
   input wire logic [15:0] cmd_wdata_i,
   // Error reporting
   input wire logic err_push_i,
   input wire logic [15:0] err_code_i,
   // Service request enable for the summary bits
   input wire logic [7:0] srq_enable_i,
   // Answer
   output logic rsp_valid_o,
   output logic [15:0] rsp_data_o,
   output logic [3:0] rsp_frac_o,
   output logic busy_o,
   // Status byte contribution and service request
   output logic [7:0] status_byte_o,
   output logic srq_o
);
   logic [15:0] ques_cond_r;
   logic [15:0] ques_cond_d_r;
   logic [15:0] ques_evt_r;
   logic [15:0] ques_ena_r;
   logic [15:0] oper_evt_r;
   logic [15:0] oper_ena_r;
   logic [15:0] ques_cond_nxt;
   logic ques_sum;
   logic oper_sum;
   logic cmd_take;
   logic qevt_rd;
   logic oevt_rd;
   logic cls;
   logic pop;
   logic push_ok;
   logic push_ovf;
   logic full;
   logic ovf_r;
   logic [sser_pkg::ERRQ_AW-1:0] wptr_r;
   logic [sser_pkg::ERRQ_AW-1:0] rptr_r;
   logic [sser_pkg::ERRQ_CNT_W-1:0] cnt_r;
   logic [15:0] mem_rdata;
   logic empty_at_pop_r;
   logic [7:0] stb_nxt;
   sser_pkg::sser_state_t state_r;
   sser_pkg::sser_cmd_t cmd_r;

   assign cmd_take = cmd_valid_i && (state_r == sser_pkg::SSER_ST_IDLE);
   assign qevt_rd = cmd_take && (cmd_i == sser_pkg::SSER_CMD_QEVT_RD);
   assign oevt_rd = cmd_take && (cmd_i == sser_pkg::SSER_CMD_OEVT_RD);
   assign cls = cmd_take && (cmd_i == sser_pkg::SSER_CMD_CLS);
   assign pop = cmd_take && (cmd_i == sser_pkg::SSER_CMD_ERR_RD);

   // Condition sampling of the fault inputs
   always_comb begin
      ques_cond_nxt = sser_pkg::REG_RST;
      ques_cond_nxt[sser_pkg::QUES_VOLT_OVL] = volt_ovl_i;
      ques_cond_nxt[sser_pkg::QUES_CURR_OVL] = curr_ovl_i;
      ques_cond_nxt[sser_pkg::QUES_FREQ_NULL] = freq_null_i;
      ques_cond_nxt[sser_pkg::QUES_OHM_OVL] = ohm_ovl_i;
      ques_cond_nxt[sser_pkg::QUES_CAP_OVL] = cap_ovl_i;
      ques_cond_nxt[sser_pkg::QUES_LIM_LO] = lim_lo_i;
      ques_cond_nxt[sser_pkg::QUES_LIM_HI] = lim_hi_i;
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ques_cond_r <= sser_pkg::REG_RST;
         ques_cond_d_r <= sser_pkg::REG_RST;
      end else begin
         ques_cond_r <= ques_cond_nxt & sser_pkg::QUES_USED;
         ques_cond_d_r <= ques_cond_r;
      end
   end

   // Event latches; a new edge wins over a read or clear
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ques_evt_r <= sser_pkg::REG_RST;
      end else begin
         ques_evt_r <= ((qevt_rd || cls) ? sser_pkg::REG_RST : ques_evt_r)
            | (ques_cond_r & ~ques_cond_d_r);
      end
   end

   // Operation group reports no conditions, so its event stays clear
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         oper_evt_r <= sser_pkg::REG_RST;
      end else if (oevt_rd || cls) begin
         oper_evt_r <= sser_pkg::REG_RST;
      end else begin
         oper_evt_r <= oper_evt_r & sser_pkg::OPER_USED;
      end
   end

   // Enable masks
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ques_ena_r <= sser_pkg::REG_RST;
         oper_ena_r <= sser_pkg::REG_RST;
      end else if (cmd_take) begin
         case (cmd_i)
            sser_pkg::SSER_CMD_QENA_WR:
               ques_ena_r <= cmd_wdata_i & sser_pkg::ENA_MASK;
            sser_pkg::SSER_CMD_OENA_WR:
               oper_ena_r <= cmd_wdata_i & sser_pkg::ENA_MASK;
            sser_pkg::SSER_CMD_PRESET: begin
               ques_ena_r <= sser_pkg::REG_RST;
               oper_ena_r <= sser_pkg::REG_RST;
            end
            default: begin
               ques_ena_r <= ques_ena_r;
               oper_ena_r <= oper_ena_r;
            end
         endcase
      end
   end

   // Error queue
   assign full = (cnt_r == 4'(sser_pkg::ERRQ_DEPTH));
   assign push_ok = err_push_i && !full && !ovf_r && !pop;
   assign push_ovf = err_push_i && full && !ovf_r && !pop;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
         ovf_r <= 1'b0;
      end else if (cls) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
         ovf_r <= 1'b0;
      end else if (pop) begin
         if (cnt_r != '0) begin
            rptr_r <= rptr_r + 3'h1;
            cnt_r <= cnt_r - 4'h1;
         end else begin
            // Overflow code is handed out last, then storing resumes
            ovf_r <= 1'b0;
         end
      end else if (push_ok) begin
         wptr_r <= wptr_r + 3'h1;
         cnt_r <= cnt_r + 4'h1;
      end else if (push_ovf) begin
         ovf_r <= 1'b1;
      end
   end

   sser_errq_mem u_mem (
      .clk_i   (clk_i),
      .we_i    (push_ok),
      .waddr_i (wptr_r),
      .wdata_i (err_code_i),
      .raddr_i (rptr_r),
      .rdata_o (mem_rdata)
   );

   // Query sequencer: take, wait a cycle for memory, answer
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state_r <= sser_pkg::SSER_ST_IDLE;
         cmd_r <= sser_pkg::SSER_CMD_NONE;
         empty_at_pop_r <= 1'b0;
      end else begin
         case (state_r)
            sser_pkg::SSER_ST_IDLE: begin
               if (cmd_take) begin
                  state_r <= sser_pkg::SSER_ST_READ;
                  cmd_r <= cmd_i;
                  empty_at_pop_r <= (cnt_r == '0) && !ovf_r;
               end
            end
            sser_pkg::SSER_ST_READ: state_r <= sser_pkg::SSER_ST_ANSW;
            sser_pkg::SSER_ST_ANSW: state_r <= sser_pkg::SSER_ST_IDLE;
            default: state_r <= sser_pkg::SSER_ST_IDLE;
         endcase
      end
   end

   // Read data is captured at the take so the clearing read returns it
   logic [15:0] snap_r;
   logic ovf_at_pop_r;
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         snap_r <= '0;
         ovf_at_pop_r <= 1'b0;
      end else if (cmd_take) begin
         ovf_at_pop_r <= ovf_r && (cnt_r == '0);
         case (cmd_i)
            sser_pkg::SSER_CMD_QCOND_RD: snap_r <= ques_cond_r;
            sser_pkg::SSER_CMD_QEVT_RD: snap_r <= ques_evt_r;
            sser_pkg::SSER_CMD_QENA_RD: snap_r <= ques_ena_r;
            sser_pkg::SSER_CMD_OCOND_RD: snap_r <= sser_pkg::REG_RST;
            sser_pkg::SSER_CMD_OEVT_RD: snap_r <= oper_evt_r;
            sser_pkg::SSER_CMD_OENA_RD: snap_r <= oper_ena_r;
            sser_pkg::SSER_CMD_VER_RD: snap_r <= sser_pkg::VER_MAJOR;
            default: snap_r <= '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rsp_valid_o <= 1'b0;
         rsp_data_o <= '0;
      end else if (state_r == sser_pkg::SSER_ST_READ) begin
         rsp_valid_o <= 1'b1;
         if (cmd_r == sser_pkg::SSER_CMD_ERR_RD) begin
            if (empty_at_pop_r) begin
               rsp_data_o <= sser_pkg::ERR_NONE;
            end else if (ovf_at_pop_r) begin
               rsp_data_o <= sser_pkg::ERR_OVERFLOW;
            end else begin
               rsp_data_o <= mem_rdata;
            end
         end else begin
            rsp_data_o <= snap_r;
         end
      end else begin
         rsp_valid_o <= 1'b0;
      end
   end

   // Tenths of the version number, shown with every answer
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rsp_frac_o <= '0;
      end else if (state_r == sser_pkg::SSER_ST_READ) begin
         rsp_frac_o <= sser_pkg::VER_MINOR;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= cmd_take || (state_r == sser_pkg::SSER_ST_READ);
      end
   end

   // Summary bits and service request
   assign ques_sum = |(ques_evt_r & ques_ena_r & sser_pkg::QUES_USED);
   assign oper_sum = |(oper_evt_r & oper_ena_r & sser_pkg::OPER_USED);

   always_comb begin
      stb_nxt = 8'h00;
      stb_nxt[sser_pkg::STB_QUES_BIT] = ques_sum;
      stb_nxt[sser_pkg::STB_OPER_BIT] = oper_sum;
      stb_nxt[sser_pkg::STB_ERR_BIT] = (cnt_r != '0) || ovf_r;
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         status_byte_o <= 8'h00;
      end else begin
         status_byte_o <= stb_nxt;
      end
   end

   // Request uses the same next byte so both outputs move together
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         srq_o <= 1'b0;
      end else begin
         srq_o <= |(stb_nxt & srq_enable_i);
      end
   end
endmodule

// *** sser_pkg.sv ***
// Constants and types for the status event register block
package sser_pkg;
   // Query / command codes on the command port
   typedef enum logic [3:0] {
      SSER_CMD_NONE      = 4'h0,
      SSER_CMD_QCOND_RD  = 4'h1,
      SSER_CMD_QEVT_RD   = 4'h2,
      SSER_CMD_QENA_RD   = 4'h3,
      SSER_CMD_QENA_WR   = 4'h4,
      SSER_CMD_OCOND_RD  = 4'h5,
      SSER_CMD_OEVT_RD   = 4'h6,
      SSER_CMD_OENA_RD   = 4'h7,
      SSER_CMD_OENA_WR   = 4'h8,
      SSER_CMD_PRESET    = 4'h9,
      SSER_CMD_CLS       = 4'hA,
      SSER_CMD_ERR_RD    = 4'hB,
      SSER_CMD_VER_RD    = 4'hC
   } sser_cmd_t;

   localparam int REG_W = 16;
   localparam logic [15:0] REG_RST = 16'h0000;
   localparam logic [15:0] ENA_MASK = 16'h7FFF;
   // Implemented questionable bits: 0,1,5,9,10,11,12
   localparam logic [15:0] QUES_USED = 16'h1E23;
   localparam logic [15:0] OPER_USED = 16'h0000;
   localparam int QUES_VOLT_OVL = 0;
   localparam int QUES_CURR_OVL = 1;
   localparam int QUES_FREQ_NULL = 5;
   localparam int QUES_OHM_OVL = 9;
   localparam int QUES_CAP_OVL = 10;
   localparam int QUES_LIM_LO = 11;
   localparam int QUES_LIM_HI = 12;
   localparam int STB_QUES_BIT = 3;
   localparam int STB_OPER_BIT = 7;
   localparam int STB_ERR_BIT = 2;

   // Error queue
   localparam int ERRQ_DEPTH = 8;
   localparam int ERRQ_AW = 3;
   localparam int ERRQ_CNT_W = 4;
   localparam int ERR_CODE_W = 16;
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] ERR_OVERFLOW = 16'hFEA2; // -350

   // Version 1994.0 as fixed-point: year and tenths
   localparam logic [15:0] VER_MAJOR = 16'h07CA; // 1994
   localparam logic [3:0] VER_MINOR = 4'h0;

   typedef enum logic [1:0] {
      SSER_ST_IDLE = 2'b00,
      SSER_ST_READ = 2'b01,
      SSER_ST_ANSW = 2'b11
   } sser_state_t;
endpackage

// *** sser_errq_mem.sv ***
// Small memory holding error queue codes
`timescale 1ns/1ps
module sser_errq_mem (
   // Clock
   input wire logic clk_i,
   // Write port
   input wire logic we_i,
   input wire logic [sser_pkg::ERRQ_AW-1:0] waddr_i,
   input wire logic [sser_pkg::ERR_CODE_W-1:0] wdata_i,
   // Read port
   input wire logic [sser_pkg::ERRQ_AW-1:0] raddr_i,
   output logic [sser_pkg::ERR_CODE_W-1:0] rdata_o
);
   logic [sser_pkg::ERR_CODE_W-1:0] mem [sser_pkg::ERRQ_DEPTH];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      rdata_o <= mem[raddr_i];
   end
endmodule

// *** sser_status_assertions.sv ***
// Port level checks for the status register block
`timescale 1ns/1ps
module sser_status_assertions (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Command side
   input wire logic cmd_valid_i,
   input wire sser_pkg::sser_cmd_t cmd_i,
   input wire logic [7:0] srq_enable_i,
   // Answer side
   input wire logic rsp_valid_o,
   input wire logic [15:0] rsp_data_o,
   input wire logic [3:0] rsp_frac_o,
   input wire logic busy_o,
   input wire logic [7:0] status_byte_o,
   input wire logic srq_o
);
   sser_pkg::sser_cmd_t cmd_r;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   // Last command taken, for judging its answer
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cmd_r <= sser_pkg::SSER_CMD_NONE;
      end else if (cmd_valid_i && !busy_o) begin
         cmd_r <= cmd_i;
      end
   end
   a_cmd_answer: assert property (cmd_valid_i && !busy_o |=>
      (busy_o && !rsp_valid_o) ##1 (busy_o && rsp_valid_o) ##1
      (!busy_o && !rsp_valid_o))
      else $error("answer timing after take wrong");
   a_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
      else $error("answer pulse longer than one cycle");
   a_oper_zero: assert property (rsp_valid_o &&
      (cmd_r == sser_pkg::SSER_CMD_OCOND_RD ||
      cmd_r == sser_pkg::SSER_CMD_OEVT_RD) |-> rsp_data_o == 16'h0000)
      else $error("operation group read not zero");
   a_ena_top: assert property (rsp_valid_o &&
      (cmd_r == sser_pkg::SSER_CMD_QENA_RD ||
      cmd_r == sser_pkg::SSER_CMD_OENA_RD) |-> !rsp_data_o[15])
      else $error("enable bit 15 read as one");
   a_ver_text: assert property (rsp_valid_o &&
      cmd_r == sser_pkg::SSER_CMD_VER_RD |->
      rsp_data_o == 16'h07CA && rsp_frac_o == 4'h0)
      else $error("version answer wrong");
   a_ques_used: assert property (rsp_valid_o &&
      (cmd_r == sser_pkg::SSER_CMD_QCOND_RD ||
      cmd_r == sser_pkg::SSER_CMD_QEVT_RD) |->
      (rsp_data_o & 16'hE1DC) == 16'h0000)
      else $error("unused questionable bit read as one");
   a_stb_unused: assert property (
      status_byte_o[1:0] == 2'b00 && !status_byte_o[7])
      else $error("unused status byte bit set");
   a_srq_mask: assert property (
      srq_o == |(status_byte_o & $past(srq_enable_i)))
      else $error("service request not the masked status byte");
endmodule
bind sser_status sser_status_assertions i_sser_status_assertions (
   .clk_i(clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
   .cmd_i(cmd_i), .srq_enable_i(srq_enable_i),
   .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
   .rsp_frac_o(rsp_frac_o), .busy_o(busy_o),
   .status_byte_o(status_byte_o), .srq_o(srq_o));

// *** sser_ctrl_model.sv ***
// Remote controller model driving the command port
`timescale 1ns/1ps
module sser_ctrl_model (
   // Clock
   input wire logic clk_i,
   // Command port
   output logic cmd_valid_o,
   output sser_pkg::sser_cmd_t cmd_o,
   output logic [15:0] cmd_wdata_o,
   // Answer
   input wire logic rsp_valid_i,
   input wire logic [15:0] rsp_data_i,
   input wire logic [3:0] rsp_frac_i,
   input wire logic busy_i,
   // Outcome of the last transfer
   output logic [15:0] rdata_o,
   output logic [3:0] rfrac_o,
   output logic tmo_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_o = sser_pkg::SSER_CMD_NONE;
      cmd_wdata_o = 16'h0000;
      tmo_o = 1'b0;
   end
   task automatic xfer(input sser_pkg::sser_cmd_t c, input logic [15:0] d,
                       input logic raw);
      int n;
      n = 0;
      @(negedge clk_i);
      while (busy_i) @(negedge clk_i);
      cmd_valid_o = 1'b1;
      cmd_o = c;
      cmd_wdata_o = raw ? d : (d & 16'h7FFF);
      @(negedge clk_i);
      cmd_valid_o = 1'b0;
      cmd_o = sser_pkg::SSER_CMD_NONE;
      // Released data no longer shows the last value
      cmd_wdata_o = ~cmd_wdata_o;
      while (!rsp_valid_i && n < 8) begin
         @(negedge clk_i);
         n++;
      end
      tmo_o = (n == 8);
      rdata_o = rsp_data_i;
      rfrac_o = rsp_frac_i;
   endtask
endmodule

// *** sser_status_tb.sv ***
// Self-checking bench for the status register block
`timescale 1ns/1ps
module sser_status_tb;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [6:0] cond = 7'h00;
   logic err_push_i = 1'b0;
   logic [15:0] err_code_i = 16'h0000;
   logic [7:0] srq_enable_i = 8'h00;
   logic cmd_valid_i, rsp_valid_o, busy_o, srq_o, tmo;
   sser_pkg::sser_cmd_t cmd_i;
   logic [15:0] cmd_wdata_i, rsp_data_o, rdata, v;
   logic [15:0] ev[9];
   logic [3:0] rsp_frac_o, rfrac;
   logic [7:0] status_byte_o;
   logic [31:0] seed = 32'h77DF9137;
   int mismatches = 0;
   int num_checks = 0;
   int i;
   always #50 clk_i = ~clk_i;
   sser_status i_sser_status (.clk_i(clk_i), .rstn_i(rstn_i),
      .volt_ovl_i(cond[0]), .curr_ovl_i(cond[1]), .freq_null_i(cond[2]),
      .ohm_ovl_i(cond[3]), .cap_ovl_i(cond[4]), .lim_lo_i(cond[5]),
      .lim_hi_i(cond[6]), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
      .cmd_wdata_i(cmd_wdata_i), .err_push_i(err_push_i),
      .err_code_i(err_code_i), .srq_enable_i(srq_enable_i),
      .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
      .rsp_frac_o(rsp_frac_o), .busy_o(busy_o),
      .status_byte_o(status_byte_o), .srq_o(srq_o));
   sser_ctrl_model i_sser_ctrl_model (.clk_i(clk_i),
      .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .cmd_wdata_o(cmd_wdata_i),
      .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
      .rsp_frac_i(rsp_frac_o), .busy_i(busy_o), .rdata_o(rdata),
      .rfrac_o(rfrac), .tmo_o(tmo));
   // Condition pins to questionable bits 0,1,5,9,10,11,12
   function automatic logic [15:0] qmap(input logic [6:0] c);
      return {3'h0, c[6:3], 3'h0, c[2], 3'h0, c[1:0]};
   endfunction
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask
   task automatic cmd(input sser_pkg::sser_cmd_t c, input logic [15:0] d,
                      input logic raw = 1'b0);
      i_sser_ctrl_model.xfer(c, d, raw);
      if (tmo !== 1'b0) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, tmo, 1'b0);
         mismatches++;
      end
   endtask
   task automatic rd(input sser_pkg::sser_cmd_t c, input logic [15:0] exp);
      cmd(c, 16'h0000);
      chk(rdata, exp);
   endtask
   task automatic push(input logic [15:0] c);
      @(negedge clk_i);
      err_push_i = 1'b1;
      err_code_i = c;
      @(negedge clk_i);
      err_push_i = 1'b0;
      err_code_i = ~c;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // About forty times the expected run length
   initial begin
      #1000000;
      mismatches++;
      end_of_test();
   end
   initial begin
      repeat (2) @(negedge clk_i);
      rstn_i = 1'b1;
      for (i = 1; i < 8; i++)
         if (i != 4) rd(sser_pkg::sser_cmd_t'(i), 16'h0000);
      $display("test reset done");
      cmd(sser_pkg::SSER_CMD_VER_RD, 16'h0000);
      chk(rdata, 16'h07CA);
      chk({12'h000, rfrac}, 16'h0000);
      v = 16'(rnd());
      cmd(sser_pkg::SSER_CMD_QENA_WR, v | 16'h8000, 1'b1);
      rd(sser_pkg::SSER_CMD_QENA_RD, v & 16'h7FFF);
      cmd(sser_pkg::SSER_CMD_OENA_WR, 16'hFFFF, 1'b1);
      rd(sser_pkg::SSER_CMD_OENA_RD, 16'h7FFF);
      cmd(sser_pkg::SSER_CMD_OENA_WR, 16'h7FFF);
      rd(sser_pkg::SSER_CMD_OENA_RD, 16'h7FFF);
      cmd(sser_pkg::SSER_CMD_PRESET, 16'h0000);
      rd(sser_pkg::SSER_CMD_QENA_RD, 16'h0000);
      rd(sser_pkg::SSER_CMD_OENA_RD, 16'h0000);
      $display("test enable done");
      for (i = 0; i < 6; i++) begin
         cond = (i == 0) ? 7'h7F : 7'(rnd());
         repeat (4) @(negedge clk_i);
         v = qmap(cond);
         rd(sser_pkg::SSER_CMD_QCOND_RD, v);
         rd(sser_pkg::SSER_CMD_QCOND_RD, v);
         cond = 7'h00;
         repeat (3) @(negedge clk_i);
         rd(sser_pkg::SSER_CMD_QCOND_RD, 16'h0000);
         rd(sser_pkg::SSER_CMD_QEVT_RD, v);
         rd(sser_pkg::SSER_CMD_QEVT_RD, 16'h0000);
      end
      $display("test events done");
      srq_enable_i = 8'h08;
      cmd(sser_pkg::SSER_CMD_QENA_WR, 16'h0001);
      cond = 7'h02;
      repeat (4) @(negedge clk_i);
      chk({8'h00, status_byte_o}, 16'h0000);
      cond = 7'h03;
      repeat (4) @(negedge clk_i);
      chk({8'h00, status_byte_o}, 16'h0008);
      chk({15'h0000, srq_o}, 16'h0001);
      cmd(sser_pkg::SSER_CMD_CLS, 16'h0000);
      repeat (3) @(negedge clk_i);
      chk({8'h00, status_byte_o}, 16'h0000);
      rd(sser_pkg::SSER_CMD_QEVT_RD, 16'h0000);
      cond = 7'h00;
      $display("test summary done");
      rd(sser_pkg::SSER_CMD_ERR_RD, 16'h0000);
      for (i = 0; i < 9; i++) begin
         ev[i] = 16'(rnd()) | 16'h8000;
         push(ev[i]);
      end
      for (i = 0; i < 8; i++)
         rd(sser_pkg::SSER_CMD_ERR_RD, ev[i]);
      rd(sser_pkg::SSER_CMD_ERR_RD, 16'hFEA2);
      rd(sser_pkg::SSER_CMD_ERR_RD, 16'h0000);
      $display("test errors done");
      end_of_test();
   end
endmodule
